// File: hw/mmd_pkg.sv
/*
  Constants and carriers for the core memory map decoder: program counter
  widths and vectors, data bank layout, core register offsets and reset values.
  Assumes a single core clock and that the user includes this package first.
*/
package mmd_pkg;

  // Program side
  localparam int          PC_W        = 13;
  localparam int          PM_ADDR_W   = 12;
  localparam logic [12:0] RESET_VEC   = 13'h0000;
  localparam logic [12:0] IRQ_VEC     = 13'h0004;

  // Data side
  localparam int          OFS_W       = 7;
  localparam int          BANK_W      = 2;
  localparam int          DADDR_W     = 9;
  localparam logic [6:0]  BANK_TOP    = 7'h7f;
  localparam logic [6:0]  SFR_TOP     = 7'h20;
  localparam logic [6:0]  COMMON_LO   = 7'h70;
  localparam logic [1:0]  COMMON_BANK = 2'h0;

  // Core registers reachable in every bank
  localparam logic [6:0]  OFS_INDIRECT = 7'h00;
  localparam logic [6:0]  OFS_STATUS   = 7'h03;
  localparam logic [6:0]  OFS_FSP      = 7'h04;

  // Data EEPROM pointer, only in one bank
  localparam logic [6:0]  OFS_EE_PTR   = 7'h0d;
  localparam logic [1:0]  BANK_EE_PTR  = 2'h2;
  localparam int          EE_ADDR_W    = 8;

  localparam int          STATUS_BSH_BIT = 6;
  localparam int          STATUS_BSL_BIT = 5;
  localparam logic [7:0]  STATUS_RST     = 8'h00;
  localparam logic [7:0]  FSP_RST        = 8'h00;
  localparam logic [7:0]  EE_PTR_RST     = 8'h00;
  localparam logic [7:0]  RDATA_RST      = 8'h00;

  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_CORE,
    ACC_SFR,
    ACC_GPR
  } mmd_acc_e;

  // Request from the instruction decoder for one data access
  typedef struct packed {
    logic       valid;
    logic       we;
    logic       indirect;
    logic [6:0] ofs;
    logic [7:0] wdata;
  } mmd_dreq_s;

  // Decoded access presented on the data memory bus
  typedef struct packed {
    logic       sfr_sel;
    logic       gpr_sel;
    logic       we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } mmd_dbus_s;

endpackage

// File: hw/mmd_decoder.sv
/*
  Memory map decoder of a small core: program counter and fetch address,
  bank-selected direct and pointer-indirect data addressing, the core
  registers mirrored in every bank, and the data EEPROM pointer.
  Assumes program flash, peripheral registers and static RAM sit outside and
  answer on the buses this block drives; all inputs are synchronous to clk.
*/
`timescale 1ns/1ps

// Behaviour
// - Program and data accesses use separate buses, both usable in one cycle.
// - Program counter is 13 bits, spanning 8K words of 14 bits.
// - Only words 0000h-0FFFh exist; higher fetch addresses wrap onto them.
// - Reset starts at 0000h; a taken interrupt continues at 0004h.
// - Status bit 6 and bit 5 select banks 0 to 3.
// - Each bank spans offsets 00h to 7Fh, 128 bytes.
// - Special function registers sit low in each bank, static RAM above.
// - Status, file select pointer and indirect slot are mirrored in all four banks; the EEPROM pointer sits in bank 2 only.
// - Data EEPROM is off the map, reached only through its address pointer.
// - Register file reachable directly or through the file select pointer.
module mmd_decoder #(
  parameter int PC_W    = mmd_pkg::PC_W,
  parameter int PM_AW   = mmd_pkg::PM_ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              pc_step,
  input  wire logic              pc_load,
  input  wire logic [PC_W-1:0]   pc_load_val,
  input  wire logic              irq_take,
  input  wire mmd_pkg::mmd_dreq_s dreq,
  input  wire logic              ee_rd_req,
  input  wire logic              ee_wr_req,
  output logic [PC_W-1:0]        pc_r,
  output logic [PM_AW-1:0]       pm_addr_r,
  output mmd_pkg::mmd_dbus_s     dbus_r,
  output logic [7:0]             core_rdata_r,
  output logic                   core_rvalid_r,
  output logic [7:0]             status_r,
  output logic [7:0]             file_select_pointer_r,
  output logic [7:0]             ee_ptr_r,
  output logic                   ee_rd_r,
  output logic                   ee_wr_r
);

  logic [PC_W-1:0]        pc_nxt;
  logic [PM_AW-1:0]       pm_addr_nxt;
  mmd_pkg::mmd_dbus_s     dbus_nxt;
  logic [7:0]             core_rdata_nxt;
  logic                   core_rvalid_nxt;
  logic [7:0]             status_nxt;
  logic [7:0]             file_select_pointer_nxt;
  logic [7:0]             ee_ptr_nxt;
  logic                   ee_rd_nxt;
  logic                   ee_wr_nxt;

  logic                   bank_select_high;
  logic                   bank_select_low;
  logic [1:0]             bank;
  logic [6:0]             ofs;
  logic [8:0]             full_addr;
  logic [8:0]             raw_addr;
  logic [3:0]             bank_hit;
  mmd_pkg::mmd_acc_e      acc;

  assign bank_select_high = status_r[mmd_pkg::STATUS_BSH_BIT];
  assign bank_select_low  = status_r[mmd_pkg::STATUS_BSL_BIT];

  // Program side: vectors win over any step or load in the same cycle
  always_comb begin
    pc_nxt = pc_r;
    if (irq_take) begin
      pc_nxt = PC_W'(mmd_pkg::IRQ_VEC);
    end else if (pc_load) begin
      pc_nxt = pc_load_val;
    end else if (pc_step) begin
      pc_nxt = PC_W'(pc_r + 1'b1);
    end
    // Upper counter bits are kept but never reach flash, so fetches alias
    pm_addr_nxt = pc_nxt[PM_AW-1:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r      <= PC_W'(mmd_pkg::RESET_VEC);
      pm_addr_r <= PM_AW'(mmd_pkg::RESET_VEC);
    end else begin
      pc_r      <= pc_nxt;
      pm_addr_r <= pm_addr_nxt;
    end
  end

  // Data side address formation: direct or through the pointer
  always_comb begin
    // Direct: the two bank bits sit above the 7-bit offset
    raw_addr = {bank_select_high, bank_select_low, dreq.ofs};
    if (dreq.indirect) begin
      // The pointer carries the low bank bit; the high one comes from status
      raw_addr = {bank_select_high, file_select_pointer_r};
    end
  end

  assign bank = raw_addr[8:7];
  assign ofs  = raw_addr[6:0];

  // One-hot bank decode, one slice per bank
  for (genvar b = 0; b < $bits(bank_hit); b++) begin : g_bank
    assign bank_hit[b] = (bank == 2'(b));
  end

  // Access classification; core registers win over the outside decode
  always_comb begin
    acc = mmd_pkg::ACC_NONE;
    if (dreq.valid) begin
      if (ofs == mmd_pkg::OFS_INDIRECT || ofs == mmd_pkg::OFS_STATUS ||
          ofs == mmd_pkg::OFS_FSP) begin
        acc = mmd_pkg::ACC_CORE;
      end else if (ofs == mmd_pkg::OFS_EE_PTR && bank_hit[mmd_pkg::BANK_EE_PTR]) begin
        acc = mmd_pkg::ACC_CORE;
      end else if (ofs < mmd_pkg::SFR_TOP) begin
        acc = mmd_pkg::ACC_SFR;
      end else begin
        acc = mmd_pkg::ACC_GPR;
      end
    end
    full_addr = raw_addr;
    // Common RAM strip folds onto one bank so all banks share it
    if (acc == mmd_pkg::ACC_GPR && ofs >= mmd_pkg::COMMON_LO) begin
      full_addr = {mmd_pkg::COMMON_BANK, ofs};
    end
  end

  // Data bus group: the decoded outside access goes out one cycle later,
  // independent of the fetch address so both buses run in the same cycle
  always_comb begin
    dbus_nxt         = '0;
    dbus_nxt.addr    = full_addr;
    dbus_nxt.we      = dreq.we;
    dbus_nxt.wdata   = dreq.wdata;
    dbus_nxt.sfr_sel = (acc == mmd_pkg::ACC_SFR);
    dbus_nxt.gpr_sel = (acc == mmd_pkg::ACC_GPR);
  end

  // Select bits pulse once per request; address and data simply follow it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbus_r <= '0;
    end else begin
      dbus_r <= dbus_nxt;
    end
  end

  // Core register group: mirrored registers answer here, never on the outside bus
  // Writes give no read pulse; only reads of the core registers answer
  always_comb begin
    core_rvalid_nxt         = (acc == mmd_pkg::ACC_CORE) && !dreq.we;
    core_rdata_nxt          = mmd_pkg::RDATA_RST;
    status_nxt              = status_r;
    file_select_pointer_nxt = file_select_pointer_r;
    ee_ptr_nxt              = ee_ptr_r;
    if (acc == mmd_pkg::ACC_CORE) begin
      case (ofs)
        mmd_pkg::OFS_STATUS: begin
          core_rdata_nxt = status_r;
          if (dreq.we) begin
            status_nxt = dreq.wdata;
          end
        end
        mmd_pkg::OFS_FSP: begin
          core_rdata_nxt = file_select_pointer_r;
          if (dreq.we) begin
            file_select_pointer_nxt = dreq.wdata;
          end
        end
        mmd_pkg::OFS_EE_PTR: begin
          core_rdata_nxt = ee_ptr_r;
          if (dreq.we) begin
            ee_ptr_nxt = dreq.wdata;
          end
        end
        // Indirect slot itself has no storage; pointing it at itself reads 0
        default: begin
          core_rdata_nxt = mmd_pkg::RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rdata_r          <= mmd_pkg::RDATA_RST;
      core_rvalid_r         <= 1'b0;
      status_r              <= mmd_pkg::STATUS_RST;
      file_select_pointer_r <= mmd_pkg::FSP_RST;
      ee_ptr_r              <= mmd_pkg::EE_PTR_RST;
    end else begin
      core_rdata_r          <= core_rdata_nxt;
      core_rvalid_r         <= core_rvalid_nxt;
      status_r              <= status_nxt;
      file_select_pointer_r <= file_select_pointer_nxt;
      ee_ptr_r              <= ee_ptr_nxt;
    end
  end

  // EEPROM strobe group: strobes carry no address of their own, only the pointer
  always_comb begin
    // A write wins over a read asked in the same cycle
    ee_rd_nxt = ee_rd_req && !ee_wr_req;
    ee_wr_nxt = ee_wr_req;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ee_rd_r <= 1'b0;
      ee_wr_r <= 1'b0;
    end else begin
      ee_rd_r <= ee_rd_nxt;
      ee_wr_r <= ee_wr_nxt;
    end
  end

endmodule // mmd_decoder

// File: test/mmd_checker.sv
/* Port properties of the memory map decoder.
   Assumes it is bound onto mmd_decoder, one clock, async low reset. */
`timescale 1ns/1ps
module mmd_checker #(
  parameter int PC_W  = 13,
  parameter int PM_AW = 12
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               pc_step,
  input wire logic               pc_load,
  input wire logic [PC_W-1:0]    pc_load_val,
  input wire logic               irq_take,
  input wire mmd_pkg::mmd_dreq_s dreq,
  input wire logic               ee_rd_req,
  input wire logic               ee_wr_req,
  input wire logic [PC_W-1:0]    pc_r,
  input wire logic [PM_AW-1:0]   pm_addr_r,
  input wire mmd_pkg::mmd_dbus_s dbus_r,
  input wire logic [7:0]         core_rdata_r,
  input wire logic               core_rvalid_r,
  input wire logic [7:0]         status_r,
  input wire logic [7:0]         file_select_pointer_r,
  input wire logic [7:0]         ee_ptr_r,
  input wire logic               ee_rd_r,
  input wire logic               ee_wr_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Plain RAM offsets only; common RAM folds its bank bits
  sequence s_dir;
    dreq.valid && !dreq.indirect && dreq.ofs >= 7'h20 && dreq.ofs < 7'h70;
  endsequence
  sequence s_ind;
    dreq.valid && dreq.indirect && file_select_pointer_r[6:0] inside {[7'h20:7'h6f]};
  endsequence
  a_fetch_wrap: assert property (pm_addr_r == pc_r[PM_AW-1:0])
    else $error("fetch address not wrapped");
  a_irq_vector: assert property (irq_take |=> pc_r == mmd_pkg::IRQ_VEC)
    else $error("interrupt vector wrong");
  a_pc_load: assert property (
    !irq_take && pc_load |=> pc_r == $past(pc_load_val))
    else $error("jump target not loaded");
  a_pc_step: assert property (
    !irq_take && !pc_load && pc_step |=> pc_r == $past(pc_r) + 1'b1)
    else $error("counter did not step");
  a_bank_addr: assert property (
    s_dir |=> dbus_r.gpr_sel &&
      dbus_r.addr == {$past(status_r[6:5]), $past(dreq.ofs)})
    else $error("direct address wrong");
  a_ind_addr: assert property (
    s_ind |=> dbus_r.gpr_sel &&
      dbus_r.addr == {$past(status_r[6]), $past(file_select_pointer_r)})
    else $error("indirect address wrong");
  a_status_mirror: assert property (
    dreq.valid && dreq.we && !dreq.indirect && dreq.ofs == mmd_pkg::OFS_STATUS |=>
      status_r == $past(dreq.wdata) && !dbus_r.sfr_sel && !dbus_r.gpr_sel)
    else $error("status write lost");
  a_sfr_low: assert property (
    dreq.valid && !dreq.indirect && dreq.ofs inside {[7'h05:7'h0c]} |=>
      dbus_r.sfr_sel && !dbus_r.gpr_sel)
    else $error("low offset not a register");
  a_ee_read: assert property (ee_rd_req && !ee_wr_req |=> ee_rd_r && !ee_wr_r)
    else $error("eeprom read strobe wrong");
  a_ee_write: assert property (ee_wr_req |=> ee_wr_r && !ee_rd_r)
    else $error("eeprom write strobe wrong");
  a_bus_follow: assert property (
    dreq.valid |=> dbus_r.we == $past(dreq.we) && dbus_r.wdata == $past(dreq.wdata))
    else $error("bus write fields wrong");
endmodule // mmd_checker
bind mmd_decoder mmd_checker #(.PC_W(PC_W), .PM_AW(PM_AW)) u_mmd_checker (.clk, .rst_n, .pc_step,
  .pc_load, .pc_load_val, .irq_take, .dreq, .ee_rd_req, .ee_wr_req, .pc_r, .pm_addr_r, .dbus_r,
  .core_rdata_r, .core_rvalid_r, .status_r, .file_select_pointer_r, .ee_ptr_r, .ee_rd_r, .ee_wr_r);

// File: test/mmd_decoder_tb.sv
/* Self-checking bench of the memory map decoder.
   Assumes mmd_pkg, mmd_decoder and the bound checker are compiled first. */
`timescale 1ns/1ps
module mmd_decoder_tb;
  logic               clk = 0, rst_n = 0, pc_step = 0, pc_load = 0, irq_take = 0;
  logic               ee_rd_req = 0, ee_wr_req = 0, core_rvalid_r, ee_rd_r, ee_wr_r;
  logic [12:0]        pc_load_val = 13'h0000, pc_r, pcm = 13'h0000;
  logic [11:0]        pm_addr_r;
  logic [7:0]         core_rdata_r, status_r, file_select_pointer_r, ee_ptr_r;
  logic [7:0]         st = 8'h00, fp = 8'h00, ep = 8'h00;
  logic [31:0]        r;
  logic [21:0]        q[$];
  mmd_pkg::mmd_dreq_s dreq = '0;
  mmd_pkg::mmd_dbus_s dbus_r;
  int                 errors = 0, checks_done = 0, cyc = 0;
  always #2.5 clk = ~clk;
  mmd_decoder u_mmd_decoder (.clk, .rst_n, .pc_step, .pc_load, .pc_load_val, .irq_take, .dreq,
    .ee_rd_req, .ee_wr_req, .pc_r, .pm_addr_r, .dbus_r, .core_rdata_r, .core_rvalid_r,
    .status_r, .file_select_pointer_r, .ee_ptr_r, .ee_rd_r, .ee_wr_r);
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Every call starts and ends on a falling edge
  task automatic pcop(input logic s, l, i, input logic [12:0] v, e);
    {pc_step, pc_load, irq_take, pc_load_val} <= {s, l, i, v};
    @(negedge clk);
    chk({9'h0, pc_r}, {9'h0, e});
    chk({10'h0, pm_addr_r}, {10'h0, e[11:0]});
  endtask
  // Model the bank bits here, never read them back from the design
  task automatic acc(input logic we, ind, input logic [6:0] o, input logic [7:0] wd);
    logic [8:0] a;
    dreq <= {1'b1, we, ind, o, wd};
    a = ind ? {st[6], fp} : {st[6:5], o};
    if (a[6:0] inside {7'h00, 7'h03, 7'h04} || a == 9'h10d) begin
      if (!we) q.push_back({5'b00100, 9'h0, a[6:0] == 7'h03 ? st : a[6:0] == 7'h04 ? fp :
                            a[6:0] == 7'h0d ? ep : 8'h00});
      else if (a[6:0] == 7'h03) st = wd;
      else if (a[6:0] == 7'h04) fp = wd;
      else if (a == 9'h10d) ep = wd;
    end else if (a[6:0] < 7'h20) q.push_back({5'b10000, a, 8'h00});
    else q.push_back({5'b01000, a[6:0] >= 7'h70 ? {2'b00, a[6:0]} : a, 8'h00});
    @(negedge clk);
  endtask
  task automatic ee(input logic rd, wr);
    {ee_rd_req, ee_wr_req} <= {rd, wr};
    q.push_back({3'b000, rd & !wr, wr, 17'h0});
    @(negedge clk);
  endtask
  task automatic idle;
    {pc_step, pc_load, irq_take, ee_rd_req, ee_wr_req, dreq.valid} <= 6'h00;
    @(negedge clk);
  endtask
  always @(negedge clk) if (rst_n && (dbus_r.sfr_sel | dbus_r.gpr_sel | core_rvalid_r |
                                       ee_rd_r | ee_wr_r)) begin
    chk({dbus_r.sfr_sel, dbus_r.gpr_sel, core_rvalid_r, ee_rd_r, ee_wr_r,
         (dbus_r.sfr_sel | dbus_r.gpr_sel) ? dbus_r.addr : 9'h000, core_rdata_r},
        q.size() ? q.pop_front() : '1);
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(90015));
    repeat (10) @(negedge clk);
    rst_n = 1;
    pcop(0, 0, 0, 13'h0000, 13'h0000);
    pcop(0, 0, 1, 13'h0000, 13'h0004);
    pcop(1, 0, 0, 13'h0000, 13'h0005);
    pcop(1, 1, 1, 13'h1c20, 13'h0004);
    for (int k = 0; k < 8; k++) begin
      pcop(0, 1, 0, 13'h0020 + 13'(k) * 13'h400, 13'h0020 + 13'(k) * 13'h400);
    end
    pcop(0, 1, 0, 13'h1fff, 13'h1fff);
    pcop(1, 0, 0, 13'h0000, 13'h0000);
    idle();
    for (int b = 0; b < 4; b++) begin
      acc(1, 0, 7'h03, {1'b0, 2'(b), 5'h00});
      acc(0, 0, 7'h03, 8'h00);
      acc(0, 0, 7'h25, 8'h00);
      acc(0, 0, 7'h75, 8'h00);
      acc(0, 0, 7'h05, 8'h00);
    end
    acc(1, 0, 7'h04, 8'ha7);
    acc(0, 1, 7'h00, 8'h00);
    acc(1, 0, 7'h03, 8'h40);
    acc(1, 0, 7'h0d, 8'h5a);
    acc(0, 0, 7'h0d, 8'h00);
    idle();
    chk({14'h0, ee_ptr_r}, {14'h0, ep});
    ee(1, 0);
    ee(0, 1);
    ee(1, 1);
    // Requests are levels; drop them before the data traffic starts
    idle();
    // Fetches step on random cycles while data accesses run
    for (int n = 0; n < 40; n++) begin
      r = $urandom;
      pc_step <= r[0];
      pcm += 13'(r[0]);
      acc(r[1], r[2], r[1] ? 7'h03 : 7'h20 + 7'(r[15:8] % 8'h50), r[23:16]);
    end
    idle();
    idle();
    chk({9'h0, pc_r}, {9'h0, pcm});
    chk(22'(q.size()), 22'h0);
    chk({14'h0, status_r}, {14'h0, st});
    chk({14'h0, file_select_pointer_r}, {14'h0, fp});
    // Second reset in mid-run: counter and bank bits go back to their start
    rst_n = 0;
    @(negedge clk);
    rst_n = 1;
    pcop(0, 0, 0, 13'h0000, 13'h0000);
    chk({14'h0, status_r}, 22'h0);
    report_and_stop();
  end
endmodule // mmd_decoder_tb
